//--- rtl/sync_sel_pkg.sv
// package for the sample-clock source selector
// assumes one 100 MHz clock and a synchronous active-high reset
package sync_sel_pkg;

   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SRC_COUNT = 4;

   // frequency figures in hertz
   localparam int unsigned RATE_32K_HZ = 32_000;
   localparam int unsigned RATE_48K_HZ = 48_000;
   localparam int unsigned RATE_882_HZ = 88_200;
   localparam int unsigned RATE_96K_HZ = 96_000;
   localparam int unsigned LOCK_MIN_HZ = 28_000;
   localparam int unsigned LOCK_MAX_HZ = 103_000;
   localparam int unsigned WCK_MAX_HZ = 105_000;

   // measuring gate of one millisecond
   localparam int unsigned GATE_MS = 1;
   localparam int unsigned GATE_CYC = CLK_HZ / 1000 * GATE_MS;
   // edges counted per gate, i.e. rate in kHz
   localparam logic [7:0] LOCK_MIN_CNT = 8'(LOCK_MIN_HZ / 1000);
   localparam logic [7:0] LOCK_MAX_CNT = 8'(LOCK_MAX_HZ / 1000);
   localparam logic [7:0] WCK_MAX_CNT = 8'(WCK_MAX_HZ / 1000);
   localparam logic [7:0] SPLIT_MIN_CNT = 8'(RATE_882_HZ / 1000);
   localparam logic [7:0] BASE_MAX_CNT = 8'(RATE_48K_HZ / 1000);
   // rate match tolerance in kHz
   localparam logic [7:0] MATCH_TOL = 8'h01;

   // firmware load time of the attached box
   localparam int unsigned LOAD_TIME_US = 100;
   localparam int unsigned LOAD_CYC = LOAD_TIME_US * (CLK_HZ / 1_000_000);

   typedef enum logic [1:0]
   {
      SRC_WORD_CLOCK = 2'h0,
      SRC_OPTICAL8 = 2'h1,
      SRC_OPTICAL_SYNC = 2'h2,
      SRC_SPDIF = 2'h3
   } src_t;

   typedef enum logic [1:0]
   {
      LOCK_NONE = 2'h0,
      LOCK_VALID = 2'h1,
      LOCK_SYNC = 2'h2
   } lock_t;

   typedef enum logic [1:0]
   {
      LINK_ERROR = 2'h0,
      LINK_LOADING = 2'h1,
      LINK_CONNECTED = 2'h3,
      LINK_DISCONNECTED = 2'h2
   } link_t;

   typedef struct packed
   {
      logic auto_mode;
      src_t preferred;
      logic base_rate_wck;
      logic spdif_in_optical;
      logic spdif_out_optical;
   } cfg_t;

   typedef struct packed
   {
      logic is_slave;
      logic use_master;
      src_t reference;
      logic [7:0] ref_khz;
   } clk_status_t;

endpackage : sync_sel_pkg

//--- rtl/rate_meter.sv
// measures the edge rate of one recovered clock strobe, in kHz per gate
// assumes the strobe is already synchronous to i_sys_clk
module rate_meter
   import sync_sel_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_gate,
   input wire logic i_edge,
   input wire logic [7:0] i_max_khz,
   output logic [7:0] o_khz,
   output logic o_valid
);

   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] khz_q;
   logic [7:0] khz_d;
   logic valid_q;
   logic valid_d;

   always_comb
   begin
      cnt_d = cnt_q;
      khz_d = khz_q;
      valid_d = valid_q;
      if (i_gate)
      begin
         khz_d = cnt_q;
         valid_d = (cnt_q >= LOCK_MIN_CNT) && (cnt_q <= i_max_khz); // RULE_13
         cnt_d = {7'h00, i_edge};
      end
      else if (i_edge && cnt_q != 8'hff)
      begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         cnt_q <= 8'h00;
         khz_q <= 8'h00;
         valid_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         khz_q <= khz_d;
         valid_q <= valid_d;
      end
   end

   assign o_khz = khz_q;
   assign o_valid = valid_q;

endmodule : rate_meter

//--- rtl/audio_sync_source_selector.sv
// sample-clock source selection, lock reporting, word clock and spdif routing
// assumes recovered-clock edge strobes synchronous to i_sys_clk, one pulse per sample
// Behaviour
// RULE_01: master mode runs from the internal crystal, external inputs ignored for timing.
// RULE_02: automatic mode monitors every digital input for a valid signal continuously.
// RULE_03: valid input at playback rate becomes the clock; status shows slave.
// RULE_04: candidates are word clock, optical eight-channel, optical sync and spdif.
// RULE_05: a valid preferred source wins; otherwise remaining inputs are scanned in turn.
// RULE_06: without usable preference the first valid input is adopted.
// RULE_07: no valid candidate means automatic fallback to master on the crystal.
// RULE_08: each input reports no signal, locked, or locked and synchronous.
// RULE_09: report the active reference and its measured sample rate.
// RULE_10: system clock status shows master or slave.
// RULE_11: word clock output follows the current sample rate by default.
// RULE_12: base-rate option keeps word clock in 32 to 48 kHz, halving double rates.
// RULE_13: lock from 28 to 103 kHz; word clock input accepts up to 105 kHz.
// RULE_14: double rate with optical eight-channel preferred enters sample-split mode.
// RULE_15: in split mode each channel uses two optical slots at base frame rate.
// RULE_16: an option selects coaxial or optical receiver for spdif input.
// RULE_17: spdif always drives coaxial out, optionally copied to optical transmitter.
// RULE_18: link shows error without box, loading during firmware, then connected.
// RULE_19: disconnect stops talking to the box, which runs standalone; show disconnected.
// RULE_20: in a system exactly one device is master, all others slaves.
// RULE_21: reselect on any lock change and switch the reference glitch free.
module audio_sync_source_selector
   import sync_sel_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire cfg_t i_cfg,
   input wire logic [7:0] i_play_khz,
   input wire logic i_xtal_edge,
   input wire logic [SRC_COUNT-1:0] i_src_edge,
   input wire logic i_spdif_coax_rx,
   input wire logic i_spdif_opt_rx,
   input wire logic i_spdif_tx,
   input wire logic i_opt8_tx,
   input wire logic i_box_present,
   input wire logic i_box_fw_done,
   input wire logic i_disconnect_req,
   input wire logic i_connect_req,
   output lock_t o_lock_report [SRC_COUNT],
   output clk_status_t o_status,
   output logic o_sample_edge,
   output logic o_word_clock_out,
   output logic o_split_mode,
   output logic o_spdif_rx,
   output logic o_spdif_coax_tx,
   output logic o_opt_tx,
   output link_t o_link_state,
   output logic o_box_talk
);

   ////////////////////////////////////////////////////////////////////////////
   // gate timer for all rate meters

   logic [$clog2(GATE_CYC)-1:0] gate_cnt_q;
   logic [$clog2(GATE_CYC)-1:0] gate_cnt_d;
   logic gate;

   always_comb
   begin
      gate = (gate_cnt_q == ($clog2(GATE_CYC))'(GATE_CYC - 1));
      gate_cnt_d = gate ? '0 : gate_cnt_q + 1'b1;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         gate_cnt_q <= '0;
      else
         gate_cnt_q <= gate_cnt_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-input rate meters and lock report

   logic [7:0] src_khz [SRC_COUNT];
   logic [SRC_COUNT-1:0] src_valid;
   logic [SRC_COUNT-1:0] src_sync;

   function automatic logic rate_match(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] diff;
      diff = (a > b) ? a - b : b - a;
      return diff <= MATCH_TOL;
   endfunction : rate_match

   genvar g;
   generate
      for (g = 0; g < SRC_COUNT; g++)
      begin : g_meter
         rate_meter u_meter
         (
            .i_sys_clk(i_sys_clk),
            .i_rst(i_rst),
            .i_gate(gate),
            .i_edge(i_src_edge[g]), // RULE_02
            .i_max_khz((g == SRC_WORD_CLOCK) ? WCK_MAX_CNT : LOCK_MAX_CNT), // RULE_13
            .o_khz(src_khz[g]),
            .o_valid(src_valid[g])
         );
         // sync means locked and at the playback rate
         assign src_sync[g] = src_valid[g] && rate_match(src_khz[g], i_play_khz);
         assign o_lock_report[g] = !src_valid[g] ? LOCK_NONE : src_sync[g] ? LOCK_SYNC : LOCK_VALID; // RULE_08
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // source selection

   logic use_master_q;
   logic use_master_d;
   src_t ref_q;
   src_t ref_d;
   logic [SRC_COUNT-1:0] sync_prev_q;
   logic switch_pend_q;
   logic switch_pend_d;
   logic use_master_tgt;
   src_t ref_tgt;
   logic [7:0] ref_khz_q;
   logic [7:0] ref_khz_d;

   always_comb
   begin
      src_t cand;
      logic found;
      cand = SRC_WORD_CLOCK;
      found = 1'b0;
      ref_tgt = ref_q;
      use_master_tgt = 1'b1;
      if (i_cfg.auto_mode) // RULE_01
      begin
         if (src_sync[i_cfg.preferred]) // RULE_05
         begin
            ref_tgt = i_cfg.preferred;
            use_master_tgt = 1'b0;
         end
         else
         begin
            // scan from the one after the preference, in turn
            for (int k = 1; k < SRC_COUNT; k++)
            begin
               cand = src_t'(2'(i_cfg.preferred + 2'(k))); // RULE_04
               if (!found && src_sync[cand]) // RULE_06
               begin
                  found = 1'b1;
                  ref_tgt = cand;
               end
            end
            use_master_tgt = !found; // RULE_07
         end
      end
      // changes wait for a cycle with no sample edge so no edge is cut
      switch_pend_d = switch_pend_q || (src_sync != sync_prev_q) || (ref_tgt != ref_q)
         || (use_master_tgt != use_master_q); // RULE_21
      use_master_d = use_master_q;
      ref_d = ref_q;
      if (switch_pend_q && !o_sample_edge) // RULE_21
      begin
         use_master_d = use_master_tgt; // RULE_03
         ref_d = ref_tgt;
         // a lock change in the same cycle keeps the request alive
         switch_pend_d = (src_sync != sync_prev_q); // RULE_21
      end
      ref_khz_d = use_master_q ? i_play_khz : src_khz[ref_q]; // RULE_09
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         use_master_q <= 1'b1;
         ref_q <= SRC_WORD_CLOCK;
         sync_prev_q <= '0;
         switch_pend_q <= 1'b0;
         ref_khz_q <= 8'h00;
      end
      else
      begin
         use_master_q <= use_master_d;
         ref_q <= ref_d;
         sync_prev_q <= src_sync;
         switch_pend_q <= switch_pend_d;
         ref_khz_q <= ref_khz_d;
      end
   end

   // sample edge from crystal or the chosen recovered clock
   assign o_sample_edge = use_master_q ? i_xtal_edge : i_src_edge[ref_q]; // RULE_01 RULE_03

   always_comb
   begin
      o_status.is_slave = !use_master_q; // RULE_10
      o_status.use_master = use_master_q;
      o_status.reference = ref_q; // RULE_09
      o_status.ref_khz = ref_khz_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // word clock output and sample-split mode

   logic double_rate;
   logic halve;
   logic wck_q;
   logic wck_d;
   logic [15:0] span_q;
   logic [15:0] span_d;
   logic [15:0] half_q;
   logic [15:0] half_d;
   logic split_q;
   logic split_d;

   always_comb
   begin
      double_rate = ref_khz_q >= SPLIT_MIN_CNT;
      halve = i_cfg.base_rate_wck && (ref_khz_q > BASE_MAX_CNT); // RULE_12
      split_d = double_rate && i_cfg.auto_mode && (i_cfg.preferred == SRC_OPTICAL8); // RULE_14 RULE_15
      span_d = (span_q == 16'hffff) ? span_q : span_q + 16'h0001;
      half_d = half_q;
      wck_d = wck_q;
      if (o_sample_edge)
      begin
         // rise on every sample; the halved path toggles so one period spans two samples
         span_d = 16'h0000;
         half_d = 16'((17'(span_q) + 17'h00001) >> 1);
         wck_d = halve ? !wck_q : 1'b1; // RULE_11 RULE_12
      end
      else if (!halve && (17'(span_q) + 17'h00001 >= 17'(half_q)))
      begin
         // fall after half of the last measured sample period
         wck_d = 1'b0; // RULE_11
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         wck_q <= 1'b0;
         span_q <= 16'h0000;
         half_q <= 16'h0000;
         split_q <= 1'b0;
      end
      else
      begin
         wck_q <= wck_d;
         span_q <= span_d;
         half_q <= half_d;
         split_q <= split_d;
      end
   end

   assign o_word_clock_out = wck_q;
   assign o_split_mode = split_q; // RULE_15

   ////////////////////////////////////////////////////////////////////////////
   // spdif routing

   logic spdif_rx_q;
   logic spdif_rx_d;
   logic coax_tx_q;
   logic coax_tx_d;
   logic opt_tx_q;
   logic opt_tx_d;

   always_comb
   begin
      spdif_rx_d = i_cfg.spdif_in_optical ? i_spdif_opt_rx : i_spdif_coax_rx; // RULE_16
      coax_tx_d = i_spdif_tx; // RULE_17
      opt_tx_d = i_cfg.spdif_out_optical ? i_spdif_tx : i_opt8_tx; // RULE_17
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         spdif_rx_q <= 1'b0;
         coax_tx_q <= 1'b0;
         opt_tx_q <= 1'b0;
      end
      else
      begin
         spdif_rx_q <= spdif_rx_d;
         coax_tx_q <= coax_tx_d;
         opt_tx_q <= opt_tx_d;
      end
   end

   assign o_spdif_rx = spdif_rx_q;
   assign o_spdif_coax_tx = coax_tx_q;
   assign o_opt_tx = opt_tx_q;

   ////////////////////////////////////////////////////////////////////////////
   // box link state

   link_t link_q;
   link_t link_d;
   logic [$clog2(LOAD_CYC+1)-1:0] load_q;
   logic [$clog2(LOAD_CYC+1)-1:0] load_d;

   always_comb
   begin
      link_d = link_q;
      load_d = load_q;
      unique case (link_q)
         LINK_ERROR:
         begin
            load_d = '0;
            if (i_box_present)
               link_d = LINK_LOADING; // RULE_18
         end
         LINK_LOADING:
         begin
            if (load_q != ($clog2(LOAD_CYC+1))'(LOAD_CYC))
               load_d = load_q + 1'b1;
            if (!i_box_present)
               link_d = LINK_ERROR;
            else if (i_box_fw_done || load_q == ($clog2(LOAD_CYC+1))'(LOAD_CYC))
               link_d = LINK_CONNECTED; // RULE_18
         end
         LINK_CONNECTED:
         begin
            if (i_disconnect_req)
               link_d = LINK_DISCONNECTED; // RULE_19
            else if (!i_box_present)
               link_d = LINK_ERROR;
         end
         LINK_DISCONNECTED:
         begin
            if (i_connect_req)
               link_d = LINK_ERROR;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         link_q <= LINK_ERROR;
         load_q <= '0;
      end
      else
      begin
         link_q <= link_d;
         load_q <= load_d;
      end
   end

   assign o_link_state = link_q;
   assign o_box_talk = (link_q == LINK_LOADING) || (link_q == LINK_CONNECTED); // RULE_19

endmodule : audio_sync_source_selector

//--- verif/sync_sel_properties.sv
// assertions on the ports of the sample-clock source selector
// assumes one clock and a synchronous active-high reset
module sync_sel_properties
   import sync_sel_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire cfg_t i_cfg,
   input wire logic i_xtal_edge,
   input wire logic [SRC_COUNT-1:0] i_src_edge,
   input wire logic i_spdif_tx,
   input wire logic i_opt8_tx,
   input wire lock_t o_lock_report [SRC_COUNT],
   input wire clk_status_t o_status,
   input wire logic o_sample_edge,
   input wire logic o_word_clock_out,
   input wire logic o_split_mode,
   input wire logic o_spdif_coax_tx,
   input wire logic o_opt_tx,
   input wire link_t o_link_state,
   input wire logic o_box_talk
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   logic any_sync;
   assign any_sync = (o_lock_report[0] == LOCK_SYNC) || (o_lock_report[1] == LOCK_SYNC)
      || (o_lock_report[2] == LOCK_SYNC) || (o_lock_report[3] == LOCK_SYNC);
   ////////////////////////////////////////////////////////////////////////////
   a_master_edge: assert property (o_status.use_master |-> o_sample_edge == i_xtal_edge)
      else $error("master strobe not from crystal");
   a_slave_edge: assert property (!o_status.use_master |-> o_sample_edge == i_src_edge[o_status.reference])
      else $error("slave strobe not from reference");
   a_slave_flag: assert property (o_status.is_slave != o_status.use_master)
      else $error("slave and master flags disagree");
   a_fallback_master: assert property (!any_sync [*6] |-> o_status.use_master)
      else $error("no sync input but not master");
   a_split_auto: assert property (!i_cfg.auto_mode [*3] |-> !o_split_mode)
      else $error("split mode outside automatic mode");
   a_coax_copy: assert property (!$past(i_rst) |-> o_spdif_coax_tx == $past(i_spdif_tx))
      else $error("coaxial output not a copy of the stream");
   a_opt_route: assert property (!$past(i_rst) |->
      o_opt_tx == ($past(i_cfg.spdif_out_optical) ? $past(i_spdif_tx) : $past(i_opt8_tx)))
      else $error("optical output routed wrongly");
   a_box_talk: assert property (o_box_talk == (o_link_state inside {LINK_LOADING, LINK_CONNECTED}))
      else $error("box talk does not match link state");
   a_wck_rise: assert property (o_sample_edge && !o_word_clock_out |=> o_word_clock_out)
      else $error("word clock did not rise on a sample");
endmodule : sync_sel_properties

//--- verif/audio_src_model.sv
// partner model: external digital sources and the internal crystal
// assumes periods in clock cycles, zero keeps a strobe silent
module audio_src_model
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [31:0] i_period [5],
   output logic [4:0] o_edge
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt [5];
   // every source ticks from one shared master timebase
   always_ff @(posedge i_sys_clk)
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (i_rst || i_period[i] == 0)
         begin
            cnt[i] <= 0;
            o_edge[i] <= 1'b0;
         end
         else
         begin
            // first strobe right after reset so every gate sees whole periods
            o_edge[i] <= (cnt[i] == 0);
            cnt[i] <= (cnt[i] == i_period[i] - 1) ? 0 : cnt[i] + 1;
         end
      end
   end
endmodule : audio_src_model

//--- verif/audio_sync_source_selector_test.sv
// self-checking bench for the sample-clock source selector
// assumes the partner model makes every sample strobe
module audio_sync_source_selector_test
   import sync_sel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   cfg_t i_cfg = '0;
   logic [7:0] i_play_khz = 8'h64;
   logic i_spdif_coax_rx = 1'b0;
   logic i_spdif_opt_rx = 1'b0;
   logic i_spdif_tx = 1'b0;
   logic i_opt8_tx = 1'b0;
   logic i_box_present = 1'b0;
   logic i_box_fw_done = 1'b0;
   logic i_disconnect_req = 1'b0;
   logic i_connect_req = 1'b0;
   logic [31:0] period [5] = '{0, 1000, 5000, 2500, 2000};
   logic [4:0] strobe;
   lock_t lock [SRC_COUNT];
   clk_status_t status;
   logic smp, wck, split, spdif_rx, coax_tx, opt_tx, box_talk;
   link_t link;
   int bad_count = 0;
   int n_checks = 0;
   always #5 i_sys_clk = ~i_sys_clk;
   audio_src_model u_src (.i_sys_clk, .i_rst, .i_period(period), .o_edge(strobe));
   audio_sync_source_selector u_dut (.i_sys_clk, .i_rst, .i_cfg, .i_play_khz, .i_xtal_edge(strobe[4]),
      .i_src_edge(strobe[3:0]), .i_spdif_coax_rx, .i_spdif_opt_rx, .i_spdif_tx, .i_opt8_tx, .i_box_present,
      .i_box_fw_done, .i_disconnect_req, .i_connect_req, .o_lock_report(lock), .o_status(status),
      .o_sample_edge(smp), .o_word_clock_out(wck), .o_split_mode(split), .o_spdif_rx(spdif_rx),
      .o_spdif_coax_tx(coax_tx), .o_opt_tx(opt_tx), .o_link_state(link), .o_box_talk(box_talk));
   ////////////////////////////////////////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : step
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_sel(input src_t r, input logic [7:0] khz);
      chk("is_slave", 8'h01, 8'(status.is_slave));
      chk("reference", 8'(r), 8'(status.reference));
      chk("ref_khz", khz, status.ref_khz);
   endtask : chk_sel
   task automatic wck_count(output int n);
      logic last;
      n = 0;
      last = 1'b1;
      for (int w = 0; w < 9000 && wck !== 1'b0; w++)
         step(1);
      for (int w = 0; w < 9000 && wck !== 1'b1; w++)
         step(1);
      for (int w = 0; w < 9000 && !(last === 1'b0 && wck === 1'b1); w++)
      begin
         last = wck;
         step(1);
         n += (smp === 1'b1);
      end
   endtask : wck_count
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("use_master", 8'h01, 8'(status.use_master));
      for (int i = 0; i < 4; i++)
         chk("lock", 8'(LOCK_NONE), 8'(lock[i]));
      chk("link", 8'(LINK_ERROR), 8'(link));
      $display("test reset done");
   endtask : t_reset
   task automatic t_route;
      for (int i = 0; i < 4; i++)
      begin
         i_cfg.spdif_in_optical = i[0];
         i_cfg.spdif_out_optical = i[1];
         i_spdif_opt_rx = i[0];
         i_spdif_coax_rx = !i[0];
         i_spdif_tx = !i[0];
         i_opt8_tx = i[0];
         step(1);
         chk("spdif_rx", 8'h01, 8'(spdif_rx));
         chk("coax_tx", 8'(!i[0]), 8'(coax_tx));
         chk("opt_tx", 8'(i[1] ? !i[0] : i[0]), 8'(opt_tx));
      end
      $display("test routing done");
   endtask : t_route
   task automatic t_link;
      i_box_present = 1'b1;
      step(1);
      chk("link", 8'(LINK_LOADING), 8'(link));
      chk("box_talk", 8'h01, 8'(box_talk));
      i_box_fw_done = 1'b1;
      step(2);
      chk("link", 8'(LINK_CONNECTED), 8'(link));
      i_disconnect_req = 1'b1;
      step(1);
      i_disconnect_req = 1'b0;
      step(1);
      chk("link", 8'(LINK_DISCONNECTED), 8'(link));
      chk("box_talk", 8'h00, 8'(box_talk));
      i_box_fw_done = 1'b0;
      i_connect_req = 1'b1;
      step(1);
      i_connect_req = 1'b0;
      chk("link", 8'(LINK_ERROR), 8'(link));
      step(1);
      chk("link", 8'(LINK_LOADING), 8'(link));
      step(int'(LOAD_CYC));
      chk("link", 8'(LINK_LOADING), 8'(link));
      step(1);
      chk("link", 8'(LINK_CONNECTED), 8'(link));
      i_box_present = 1'b0;
      step(1);
      chk("link", 8'(LINK_ERROR), 8'(link));
      chk("box_talk", 8'h00, 8'(box_talk));
      $display("test link done");
   endtask : t_link
   task automatic t_lock;
      int n;
      i_cfg.auto_mode = 1'b1;
      i_cfg.preferred = SRC_SPDIF;
      for (int w = 0; w < 400000 && status.use_master !== 1'b0; w++)
         step(1);
      step(10);
      chk("lock0", 8'(LOCK_NONE), 8'(lock[0]));
      chk("lock1", 8'(LOCK_SYNC), 8'(lock[1]));
      chk("lock2", 8'(LOCK_NONE), 8'(lock[2]));
      chk("lock3", 8'(LOCK_VALID), 8'(lock[3]));
      chk_sel(SRC_OPTICAL8, 8'h64);
      chk("split", 8'h00, 8'(split));
      wck_count(n);
      chk("wck_samples", 8'h01, 8'(n));
      i_cfg.preferred = SRC_OPTICAL8;
      i_cfg.base_rate_wck = 1'b1;
      step(10);
      chk("split", 8'h01, 8'(split));
      wck_count(n);
      chk("wck_samples", 8'h02, 8'(n));
      i_play_khz = 8'h28;
      step(10);
      chk("lock3", 8'(LOCK_SYNC), 8'(lock[3]));
      chk_sel(SRC_SPDIF, 8'h28);
      chk("split", 8'h00, 8'(split));
      i_play_khz = 8'h2d;
      step(10);
      chk("use_master", 8'h01, 8'(status.use_master));
      i_play_khz = 8'h28;
      i_cfg.auto_mode = 1'b0;
      step(10);
      chk("use_master", 8'h01, 8'(status.use_master));
      $display("test lock done");
   endtask : t_lock
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #1_500_000;
      bad_count++;
      $display("BAD watchdog expected finish seen timeout");
      stop_test();
   end
   initial
   begin
      repeat (3) @(posedge i_sys_clk);
      #1;
      i_rst = 1'b0;
      step(1);
      t_reset();
      t_route();
      t_link();
      t_lock();
      stop_test();
   end
endmodule : audio_sync_source_selector_test
bind audio_sync_source_selector sync_sel_properties u_props (.i_sys_clk, .i_rst, .i_cfg, .i_xtal_edge, .i_src_edge,
   .i_spdif_tx, .i_opt8_tx, .o_lock_report, .o_status, .o_sample_edge, .o_word_clock_out, .o_split_mode,
   .o_spdif_coax_tx, .o_opt_tx,
   .o_link_state, .o_box_talk);
